// ==== testbench/hiic_host_model.sv ====
// Host bus controller model: drives the memory-bus pins of the port.
// Assumes pclk is the port clock; each phase is held 4 edges or more.
`timescale 1ns/1ps
module hiic_host_model (
    // Clock
    input  wire logic        pclk,
    // Host bus pins
    output logic             avd_n,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic      [16:0] addr,
    output logic      [15:0] data,
    input  wire logic [15:0] bus,
    input  wire logic        busy_n
);
    initial begin
        {avd_n, ce_n, oe_n, we_n} = 4'hF;
        addr = 17'h00000;
        data = 16'h5A5A;
    end
    ////////////////////////////////////////////////////////////////
    // Strobes stay put long enough for the pin synchroniser
    task automatic acc(input logic wr, input logic [16:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge pclk);
        addr <= {a[16:1], 1'b0};
        data <= d;
        ce_n <= 1'b0;
        repeat (4) @(posedge pclk);
        {oe_n, we_n} <= {wr, !wr};
        repeat (6) @(posedge pclk);
        while (!busy_n) @(posedge pclk);
        q = bus;
        {oe_n, we_n} <= 2'h3;
        repeat (4) @(posedge pclk);
        ce_n <= 1'b1;
        data <= ~d;
    endtask : acc
    // Address phase on the shared lines
    task automatic strobe(input logic [15:0] a);
        @(posedge pclk);
        data <= a;
        avd_n <= 1'b0;
        repeat (4) @(posedge pclk);
        avd_n <= 1'b1;
        data <= ~a;
        repeat (4) @(posedge pclk);
    endtask : strobe
endmodule : hiic_host_model

// ==== testbench/hiic_host_port_tb_top.sv ====
// Testbench for the host port: APB master, host model, pending model.
// Assumes one 100 MHz clock and the zero-wait APB slave of the port.
`timescale 1ns/1ps
module hiic_host_port_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic        avd_n, ce_n, oe_n, we_n, doe, busy_n, irq_out, dma_n, warm_n, lock, ids;
    logic        key_ok, id_out, software_reset_bit, c_rdy, c_bsy, c_drq, e_op, e_rd, e_wr, pend, idis, cmd_v;
    logic [16:0] haddr;
    logic [15:0] hdata, dout, bus, hq;
    logic [7:0]  cmd;
    int          seed, fail_count, checked, cycles, dma_lows, cmd_pulses;
    localparam logic [16:0] SC = {hiic_pkg::HOST_STAT_CMD, 1'b0};
    localparam logic [16:0] DC = {hiic_pkg::HOST_DEV_CTRL, 1'b0};
    // Device drives the shared lines only while enabled
    assign bus = doe ? dout : hdata;
    hiic_host_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .address_valid_strobe_n(avd_n), .chip_enable_n(ce_n),
        .output_enable_n(oe_n), .write_enable_n(we_n), .addr_in(haddr), .data_in(bus),
        .data_out(dout), .data_oe(doe), .busy_n(busy_n), .irq_out(irq_out),
        .dma_request_n(dma_n), .warm_reset_n(warm_n), .lock_in(lock),
        .chip_identity_select(ids), .core_ready(c_rdy), .core_busy(c_bsy), .core_drq(c_drq),
        .evt_op_done(e_op), .evt_rd_block(e_rd), .evt_wr_block(e_wr), .cmd_valid(cmd_v),
        .cmd_code(cmd), .soft_reset(software_reset_bit), .key_use_allowed(key_ok), .identity_sel(id_out));
    hiic_host_model host_u (.pclk(pclk), .avd_n(avd_n), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .addr(haddr), .data(hdata), .bus(bus), .busy_n(busy_n));
    ////////////////////////////////////////////////////////////////
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (!dma_n) dma_lows++;
        if (cmd_v === 1'b1) cmd_pulses++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic chk;
        apb(1'b0, hiic_pkg::APB_STAT, 32'h0);
        cmp({rd[1:0], irq_out}, {idis, pend, pend & ~idis});
    endtask : chk
    task automatic ev(input int k);
        @(posedge pclk);
        {e_op, e_rd, e_wr} <= 3'h4 >> k;
        @(posedge pclk);
        {e_op, e_rd, e_wr} <= 3'h0;
    endtask : ev
    ////////////////////////////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {lock, ids, c_rdy, c_bsy, c_drq, e_op, e_rd, e_wr, pend, idis} = '0;
        warm_n = 1'b1;
        seed = 57;
        repeat (5) @(posedge pclk);
        cmp({busy_n, irq_out, dma_n}, 3'h3);
        presetn <= 1'b1;
        apb(1'b1, hiic_pkg::APB_IRQ_CFG, 32'h1);
        apb(1'b1, hiic_pkg::APB_IRQ_CFG, 32'h2);
        apb(1'b0, hiic_pkg::APB_IRQ_CFG, 32'h0);
        cmp(rd, 32'h101);
        apb(1'b0, 8'h10, 32'h0);
        cmp(err, 1'b1);
        cmp(rd, 32'h0);
        c_rdy <= 1'b1;
        for (int n = 0; n < 50 && busy_n !== 1'b1; n++) @(posedge pclk);
        cmp(busy_n, 1'b1);
        ev(0); pend = 1; chk();
        c_bsy <= 1'b1;
        host_u.acc(1'b0, SC, 16'h0, hq); chk();
        cmp(hq[7], 1'b1);
        c_bsy <= 1'b0;
        host_u.acc(1'b0, SC, 16'h0, hq); pend = 0; chk();
        ev(1); pend = 1; chk();
        host_u.acc(1'b1, DC, 16'h4, hq); pend = 0; chk();
        cmp(software_reset_bit, 1'b1);
        host_u.acc(1'b1, DC, 16'h0, hq);
        ev(0); pend = 1;
        r = $random(seed);
        host_u.acc(1'b1, SC, {8'h00, r[7:0]}, hq); pend = 0; chk();
        cmp(cmd, r[7:0]);
        cmp(cmd_pulses, 1);
        ev(2); chk();
        ev(2); pend = 1; chk();
        host_u.acc(1'b1, DC, 16'h2, hq); idis = 1; chk();
        host_u.acc(1'b1, DC, 16'h0, hq); idis = 0; chk();
        apb(1'b1, hiic_pkg::APB_DMA, 32'h3);
        dma_lows = 0;
        ev(1);
        repeat (4) @(posedge pclk);
        cmp(dma_lows, 1);
        apb(1'b1, hiic_pkg::APB_DMA, 32'h1);
        c_drq <= 1'b1;
        repeat (3) @(posedge pclk);
        cmp(dma_n, 1'b0);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            {lock, ids} <= r[1:0];
            repeat (4) @(posedge pclk);
            cmp({key_ok, id_out}, r[1:0]);
        end
        ids <= 1'b0;
        // Shared lines carry the low sixteen byte-address bits during the strobe
        host_u.strobe(SC[15:0]);
        apb(1'b0, hiic_pkg::APB_STAT, 32'h0);
        cmp(rd[4], 1'b1);
        host_u.acc(1'b0, SC, 16'h0, hq);
        pend = 0;
        cmp(hq[3], 1'b1);
        apb(1'b1, hiic_pkg::APB_WARM, 32'h2);
        warm_n <= 1'b0;
        repeat (6) @(posedge pclk);
        cmp(busy_n, 1'b0);
        warm_n <= 1'b1;
        repeat (6) @(posedge pclk);
        pend = 0; chk();
        cmp(rd[4], 1'b0);
        apb(1'b0, hiic_pkg::APB_IRQ_CFG, 32'h0);
        cmp(rd, 32'h101);
        end_of_test();
    end
endmodule : hiic_host_port_tb_top

// ==== verilog/hiic_host_if.sv ====
// Carrier between the pin front end and the interrupt/register core.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface hiic_host_if;
    logic        mux_mode;
    logic        rd_strobe;
    logic        rd_active;
    logic        wr_strobe;
    logic [15:0] wr_data;
    logic [16:0] acc_addr;
    logic        warm_rst;
    logic        lock_level;
    logic        warm_mux;

    modport front (output mux_mode, rd_strobe, rd_active, wr_strobe, wr_data,
                   acc_addr, warm_rst, lock_level, input warm_mux);
    modport core  (input mux_mode, rd_strobe, rd_active, wr_strobe, wr_data,
                   acc_addr, warm_rst, lock_level, output warm_mux);
endinterface : hiic_host_if

// ==== verilog/hiic_host_port.sv ====
// Host interface and interrupt control: pin bus registers, interrupt
// pending logic, DMA request, busy and lock outputs, APB configuration.
// Assumes core events arrive as one-cycle pulses on pclk.
//
// Operation
// - A falling address-valid strobe switches the port into multiplexed mode.
// - In multiplexed mode the sixteen data lines also carry address bits 15:0; A16 stays on its own pin.
// - Interrupt output drives only while the interrupt-disable bit is clear.
// - Interrupt polarity and edge mode come from write-once format configuration.
// - Block operation completion makes an interrupt pending.
// - Each read block ready makes an interrupt pending.
// - Each write block acceptance raises an interrupt, except the first block.
// - Reading status while busy is clear ends the pending state.
// - Writing command with busy and data-request clear ends the pending state.
// - Setting software reset clears any pending interrupt.
// - Warm reset resets only the host interface.
// - Warm reset loads a state chosen by the warm boot register.
// - Lock low refuses protection keys, lock high allows them.
// - Busy output stays active until the device is ready for access.
// - DMA request output paces multi-block DMA transfers.
// - Standard bus uses a window, sixteen data lines and separate strobes.
// - Edge DMA mode pulses once per block, level mode follows data readiness.
`timescale 1ns/1ps
module hiic_host_port (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host bus pins
    input  wire logic        address_valid_strobe_n,
    input  wire logic        chip_enable_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic [16:0] addr_in,
    input  wire logic [15:0] data_in,
    output logic      [15:0] data_out,
    output logic             data_oe,
    output logic             busy_n,
    output logic             irq_out,
    output logic             dma_request_n,
    // Configuration pins
    input  wire logic        warm_reset_n,
    input  wire logic        lock_in,
    input  wire logic        chip_identity_select,
    // Device core side
    input  wire logic        core_ready,
    input  wire logic        core_busy,
    input  wire logic        core_drq,
    input  wire logic        evt_op_done,
    input  wire logic        evt_rd_block,
    input  wire logic        evt_wr_block,
    output logic             cmd_valid,
    output logic      [7:0]  cmd_code,
    output logic             soft_reset,
    output logic             key_use_allowed,
    output logic             identity_sel
);

    hiic_host_if hb ();

    hiic_pin_front u_front (
        .pclk                   (pclk),
        .presetn                (presetn),
        .address_valid_strobe_n (address_valid_strobe_n),
        .chip_enable_n          (chip_enable_n),
        .output_enable_n        (output_enable_n),
        .write_enable_n         (write_enable_n),
        .addr_in                (addr_in),
        .data_in                (data_in),
        .warm_reset_n           (warm_reset_n),
        .lock_in                (lock_in),
        .hb                     (hb)
    );

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [1:0]  irq_cfg_reg;
    logic        cfg_locked_reg;
    logic [1:0]  warm_reg;
    logic [1:0]  dma_cfg_reg;
    logic        idis_reg;
    logic        pending_reg;
    logic        pending_next;
    logic        pend_prev_reg;
    logic        wr_first_reg;
    logic        irq_reg;
    logic        dma_n_reg;
    logic        busy_n_reg;
    logic [15:0] dout_reg;
    logic        doe_reg;
    logic        cmd_valid_reg;
    logic [7:0]  cmd_code_reg;
    logic        software_reset_bit_reg;
    logic        key_reg;
    logic        id_s1_reg;
    logic        id_s2_reg;
    logic        id_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Decoding

    // A0 never takes part in the match
    wire         hit_stat  = hb.acc_addr[16:1] == hiic_pkg::HOST_STAT_CMD;
    wire         hit_ctrl  = hb.acc_addr[16:1] == hiic_pkg::HOST_DEV_CTRL;
    wire         stat_rd   = hb.rd_strobe & hit_stat;
    wire         cmd_wr    = hb.wr_strobe & hit_stat;
    wire         ctrl_wr   = hb.wr_strobe & hit_ctrl;
    wire         software_reset_bit_set  = ctrl_wr & hb.wr_data[hiic_pkg::CTRL_SOFTWARE_RESET_BIT_BIT];
    wire  [15:0] stat_word = {8'h00, core_busy, 3'h0, core_drq, 3'h0};
    wire  [15:0] ctrl_word = {13'h0000, software_reset_bit_reg, idis_reg, 1'b0};
    wire  [15:0] rd_word   = hit_stat ? stat_word : (hit_ctrl ? ctrl_word : 16'h0000);

    wire         apb_acc   = psel & penable;
    wire         apb_wr    = apb_acc & pwrite;
    wire         wr_cfg    = apb_wr & (paddr == hiic_pkg::APB_IRQ_CFG);
    wire         wr_warm   = apb_wr & (paddr == hiic_pkg::APB_WARM);
    wire         wr_dma    = apb_wr & (paddr == hiic_pkg::APB_DMA);
    wire         mapped    = (paddr == hiic_pkg::APB_IRQ_CFG) | (paddr == hiic_pkg::APB_WARM) |
                             (paddr == hiic_pkg::APB_DMA) | (paddr == hiic_pkg::APB_STAT);
    wire  [31:0] stat_apb  = {26'h0000000, hb.lock_level, hb.mux_mode, core_drq,
                              core_busy, idis_reg, pending_reg};
    wire  [31:0] apb_word  = (paddr == hiic_pkg::APB_IRQ_CFG) ?
                                 {23'h000000, cfg_locked_reg, 6'h00, irq_cfg_reg} :
                             (paddr == hiic_pkg::APB_WARM) ? {30'h00000000, warm_reg} :
                             (paddr == hiic_pkg::APB_DMA)  ? {30'h00000000, dma_cfg_reg} :
                             (paddr == hiic_pkg::APB_STAT) ? stat_apb : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pending

    wire         wr_raise  = evt_wr_block & ~wr_first_reg;
    wire         raise     = evt_op_done | evt_rd_block | wr_raise;
    wire         clr_stat  = stat_rd & ~core_busy;
    wire         clr_cmd   = cmd_wr & ~core_busy & ~core_drq;
    wire         clear     = clr_stat | clr_cmd | software_reset_bit_set | hb.warm_rst;

    // A raise in the clearing cycle survives the clear
    assign pending_next = raise | (pending_reg & ~clear);

    wire         irq_edge  = irq_cfg_reg[hiic_pkg::CFG_EDGE_BIT];
    wire         irq_pol   = irq_cfg_reg[hiic_pkg::CFG_POL_BIT];
    wire         irq_src   = irq_edge ? (pending_reg & ~pend_prev_reg) : pending_reg;
    wire         irq_act   = irq_src & ~idis_reg;
    wire         idis_next = hb.warm_rst ? ~warm_reg[hiic_pkg::WARM_IEN_BIT] :
                             (ctrl_wr ? hb.wr_data[hiic_pkg::CTRL_IDIS_BIT] : idis_reg);

    wire         dma_edge  = dma_cfg_reg[hiic_pkg::DMA_EDGE_BIT];
    wire         dma_act   = dma_cfg_reg[hiic_pkg::DMA_EN_BIT] &
                             (dma_edge ? (evt_rd_block | evt_wr_block) : core_drq);

    assign hb.warm_mux = warm_reg[hiic_pkg::WARM_MUX_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_reg   <= 1'b0;
            pend_prev_reg <= 1'b0;
            wr_first_reg  <= 1'b1;
            idis_reg      <= hiic_pkg::IDIS_RST;
        end else begin
            pending_reg   <= pending_next;
            pend_prev_reg <= pending_reg;
            idis_reg      <= idis_next;
            if (cmd_wr) begin
                wr_first_reg <= 1'b1;
            end else if (evt_wr_block) begin
                wr_first_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg    <= 1'b1;
            dma_n_reg  <= 1'b1;
            busy_n_reg <= 1'b0;
            key_reg    <= 1'b0;
        end else begin
            irq_reg    <= irq_act ~^ irq_pol;
            dma_n_reg  <= ~dma_act;
            busy_n_reg <= core_ready & ~hb.warm_rst;
            key_reg    <= hb.lock_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_reg      <= 16'h0000;
            doe_reg       <= 1'b0;
            cmd_valid_reg <= 1'b0;
            cmd_code_reg  <= 8'h00;
            software_reset_bit_reg      <= 1'b0;
        end else begin
            doe_reg       <= hb.rd_active & (hit_stat | hit_ctrl);
            cmd_valid_reg <= cmd_wr;
            software_reset_bit_reg      <= ctrl_wr ? hb.wr_data[hiic_pkg::CTRL_SOFTWARE_RESET_BIT_BIT] :
                             (software_reset_bit_reg & ~hb.warm_rst);
            if (hb.rd_strobe) begin
                dout_reg <= rd_word;
            end
            if (cmd_wr) begin
                cmd_code_reg <= hb.wr_data[7:0];
            end
        end
    end

    // Identity strap is a slow pin; synchronise before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_s1_reg <= 1'b0;
            id_s2_reg <= 1'b0;
            id_reg    <= 1'b0;
        end else begin
            id_s1_reg <= chip_identity_select;
            id_s2_reg <= id_s1_reg;
            id_reg    <= id_s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB configuration registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_cfg_reg    <= hiic_pkg::IRQ_CFG_RST;
            cfg_locked_reg <= 1'b0;
            warm_reg       <= hiic_pkg::WARM_RST;
            dma_cfg_reg    <= hiic_pkg::DMA_RST;
            prdata_reg     <= 32'h00000000;
            pslverr_reg    <= 1'b0;
        end else begin
            // Format-time setting: only the first write after power-up lands
            if (wr_cfg && !cfg_locked_reg) begin
                irq_cfg_reg    <= pwdata[1:0];
                cfg_locked_reg <= 1'b1;
            end
            if (wr_warm) begin
                warm_reg <= pwdata[1:0];
            end
            if (wr_dma) begin
                dma_cfg_reg <= pwdata[1:0];
            end
            prdata_reg  <= (psel && !penable && !pwrite) ? apb_word : prdata_reg;
            pslverr_reg <= psel & ~penable & ~mapped;
        end
    end

    assign prdata          = prdata_reg;
    assign pready          = 1'b1;
    // Flag is raised at the setup edge and dropped at the access edge, so it stands for the access phase only
    assign pslverr         = pslverr_reg;
    assign data_out        = dout_reg;
    assign data_oe         = doe_reg;
    assign busy_n          = busy_n_reg;
    assign irq_out         = irq_reg;
    assign dma_request_n   = dma_n_reg;
    assign cmd_valid       = cmd_valid_reg;
    assign cmd_code        = cmd_code_reg;
    assign soft_reset      = software_reset_bit_reg;
    assign key_use_allowed = key_reg;
    assign identity_sel    = id_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_IRQ_GATED: assert property (idis_reg |=> irq_reg == !$past(irq_pol))
        else $error("interrupt driven while disabled");

    AST_CFG_ONCE: assert property (cfg_locked_reg && wr_cfg |=> $stable(irq_cfg_reg))
        else $error("interrupt configuration changed after lock");

    AST_OP_DONE: assert property (evt_op_done |=> pending_reg)
        else $error("completion did not set pending");

    AST_RD_BLOCK: assert property (evt_rd_block ##1 (!idis_reg && !irq_edge)
        |=> irq_reg == irq_pol)
        else $error("read block did not drive interrupt");

    AST_WR_FIRST: assert property (evt_wr_block && wr_first_reg
        && !evt_op_done && !evt_rd_block && !pending_reg |=> !pending_reg)
        else $error("first write block raised interrupt");

    AST_STAT_CLR: assert property (clr_stat && !raise |=> !pending_reg)
        else $error("status read did not clear pending");

    AST_CMD_CLR: assert property (cmd_wr && !core_busy && !core_drq && !raise
        |=> !pending_reg ##1 cmd_valid_reg == 1'b0)
        else $error("command write did not clear pending");

    AST_SOFTWARE_RESET_BIT_CLR: assert property (software_reset_bit_set && !raise |=> !pending_reg && software_reset_bit_reg)
        else $error("software reset did not clear pending");

    AST_KEY_LOCK: assert property (##1 key_reg == $past(hb.lock_level))
        else $error("key permission does not follow lock");

    AST_BUSY: assert property (!core_ready |=> !busy_n_reg)
        else $error("busy released before ready");

    AST_DMA_EDGE: assert property (dma_cfg_reg == 2'h3 && evt_rd_block && !evt_wr_block
        ##1 !evt_rd_block && !evt_wr_block |-> !dma_n_reg ##1 dma_n_reg)
        else $error("edge DMA request not a single pulse");

    AST_WARM_IEN: assert property (hb.warm_rst |=> idis_reg == !$past(warm_reg[1]))
        else $error("warm reset did not load interrupt enable");

endmodule : hiic_host_port

// ==== verilog/hiic_pin_front.sv ====
// Host pin front end: synchronises the bus pins and finds host accesses.
// Assumes pins are asynchronous to pclk and held long enough to be sampled.
`timescale 1ns/1ps
module hiic_pin_front (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Host bus pins
    input  wire logic        address_valid_strobe_n,
    input  wire logic        chip_enable_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic [16:0] addr_in,
    input  wire logic [15:0] data_in,
    // Configuration pins
    input  wire logic        warm_reset_n,
    input  wire logic        lock_in,
    // Toward the core
    hiic_host_if.front       hb
);

    logic [38:0] raw;
    logic [38:0] s1_reg;
    logic [38:0] s2_reg;
    logic        avd_prev_reg;
    logic        rd_prev_reg;
    logic        we_prev_reg;
    logic        mux_mode_reg;
    logic        mux_next;
    logic [16:0] mux_addr_reg;

    wire         avd_s  = s2_reg[38];
    wire         ce_s   = s2_reg[37];
    wire         oe_s   = s2_reg[36];
    wire         we_s   = s2_reg[35];
    wire         warm_s = s2_reg[34];
    wire         lock_s = s2_reg[33];
    wire  [16:0] addr_s = s2_reg[32:16];
    wire  [15:0] data_s = s2_reg[15:0];
    wire         rd_act = ~ce_s & ~oe_s;
    wire         avd_fall = avd_prev_reg & ~avd_s;

    assign raw = {address_valid_strobe_n, chip_enable_n, output_enable_n,
                  write_enable_n, warm_reset_n, lock_in, addr_in, data_in};

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser; only the second stage is looked at

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= hiic_pkg::SYNC_RST;
            s2_reg <= hiic_pkg::SYNC_RST;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus mode and address capture

    // Warm reset puts the mode where the warm boot setting says
    assign mux_next = !warm_s ? hb.warm_mux :
                      (avd_fall ? 1'b1 : mux_mode_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            avd_prev_reg <= 1'b1;
            rd_prev_reg  <= 1'b0;
            we_prev_reg  <= 1'b1;
            mux_mode_reg <= 1'b0;
            mux_addr_reg <= 17'h00000;
        end else begin
            avd_prev_reg <= avd_s;
            rd_prev_reg  <= rd_act;
            we_prev_reg  <= we_s;
            mux_mode_reg <= mux_next;
            if (!avd_s) begin
                mux_addr_reg <= {addr_s[16], data_s};
            end
        end
    end

    assign hb.mux_mode   = mux_mode_reg;
    assign hb.acc_addr   = mux_mode_reg ? mux_addr_reg : addr_s;
    assign hb.rd_strobe  = rd_act & ~rd_prev_reg & warm_s;
    // In multiplexed mode data lines carry the address while avd is low, so never drive then
    assign hb.rd_active  = rd_act & (avd_s | ~mux_mode_reg);
    assign hb.wr_strobe  = we_s & ~we_prev_reg & ~ce_s & warm_s;
    assign hb.wr_data    = data_s;
    assign hb.warm_rst   = ~warm_s;
    assign hb.lock_level = lock_s;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_MUX_ENTRY: assert property (avd_fall && warm_s |=> mux_mode_reg)
        else $error("mux mode not entered after strobe fall");

endmodule : hiic_pin_front

// ==== verilog/hiic_pkg.sv ====
// Constants shared by the host interface and interrupt control block.
// Assumes one 100 MHz clock (pclk) and an active-low asynchronous reset.
package hiic_pkg;

    // APB byte offsets
    localparam logic [7:0]  APB_IRQ_CFG  = 8'h00;
    localparam logic [7:0]  APB_WARM     = 8'h04;
    localparam logic [7:0]  APB_DMA      = 8'h08;
    localparam logic [7:0]  APB_STAT     = 8'h0C;

    // Host window word addresses (address bits 16:1, A0 ignored)
    localparam logic [15:0] HOST_STAT_CMD = 16'hF807;
    localparam logic [15:0] HOST_DEV_CTRL = 16'hF80E;

    // Field positions
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_DRQ_BIT  = 3;
    localparam int CTRL_IDIS_BIT = 1;
    localparam int CTRL_SOFTWARE_RESET_BIT_BIT = 2;
    localparam int CFG_POL_BIT   = 0;
    localparam int CFG_EDGE_BIT  = 1;
    localparam int CFG_LOCK_BIT  = 8;
    localparam int WARM_MUX_BIT  = 0;
    localparam int WARM_IEN_BIT  = 1;
    localparam int DMA_EN_BIT    = 0;
    localparam int DMA_EDGE_BIT  = 1;

    // Values after reset
    localparam logic [1:0]  IRQ_CFG_RST  = 2'h0;
    localparam logic [1:0]  WARM_RST     = 2'h0;
    localparam logic [1:0]  DMA_RST      = 2'h0;
    localparam logic        IDIS_RST     = 1'b0;
    // Pin synchroniser: avd, ce, oe, we, warm all idle high; lock, addr, data low
    localparam logic [38:0] SYNC_RST     = {6'h3E, 33'h000000000};

endpackage : hiic_pkg
